// ==== gpio_consts.svh ====
// constants for the port d / port e gpio block
// assumes an axi4-lite slave with 32-bit data, one register per aligned word
`ifndef GPIO_CONSTS_SVH
`define GPIO_CONSTS_SVH
`define ADDR_W 12
`define IDX_PD_LATCH 12'h0003
`define IDX_PE_LATCH 12'h0008
// printed offsets are word indices; the bus sees byte addresses
`define OFF_PD_LATCH (`IDX_PD_LATCH << 2)
`define OFF_PE_LATCH (`IDX_PE_LATCH << 2)
`define OFF_PD_DIR 12'h0010
`define OFF_PD_CTRL 12'h0014
`define OFF_PE_DIR 12'h0018
`define CTRL_SLOW6 0
`define CTRL_SLOW7 1
`define CTRL_PU6 2
`define CTRL_PU7 3
`define CTRL_MASK 8'h0f
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define ADC_CH_PD_BASE 5'h08
`define ADC_CH_PD_LAST 5'h0b
`define ADC_PIN_BASE 4
`endif

// ==== gpio_pkg.sv ====
// types shared by the gpio block
// assumes gpio_consts.svh is compiled alongside
package gpio_pkg;
  typedef enum logic [2:0] {
    RD_IDLE = 3'b001,
    RD_RESP = 3'b010,
    RD_HOLD = 3'b100
  } rd_state_e;
  typedef enum logic [2:0] {
    WR_IDLE = 3'b001,
    WR_RESP = 3'b010,
    WR_HOLD = 3'b100
  } wr_state_e;
endpackage : gpio_pkg

// ==== pin_cell.sv ====
// one bidirectional pin: override mux, drive enable, open-drain option
// assumes pad ring resolves level from out and oe_n
`timescale 1ns/100ps
module pin_cell (
  input wire logic latch_bit,
  input wire logic dir_bit,
  input wire logic ovr_en,
  input wire logic ovr_drive,
  input wire logic ovr_data,
  input wire logic open_drain,
  output logic pin_out,
  output logic pin_oe_n
);
  logic drive;
  logic data;
  always_comb begin
    drive = ovr_en ? ovr_drive : dir_bit;
    data = ovr_en ? ovr_data : latch_bit;
    pin_out = data;
    if (open_drain) begin
      pin_out = 1'b0;
      pin_oe_n = ~(drive & ~data);
    end else begin
      pin_oe_n = ~drive;
    end
  end
endmodule : pin_cell

// ==== pin_env.sv ====
// external circuitry on a group of pins: resolves each pin level
// assumes the device drives a pin only while its oe_n is low
`timescale 1ns/100ps
module pin_env #(
  parameter int W = 8
) (
  input wire logic [W-1:0] pin_out,
  input wire logic [W-1:0] pin_oe_n,
  input wire logic [W-1:0] pull_en,
  input wire logic [W-1:0] ext_en,
  input wire logic [W-1:0] ext_val,
  output logic [W-1:0] pin_in
);
  // ==========================================
  // pin level
  // a floating pin shows the inverse of the last drive, never a kind guess
  always_comb begin
    for (int i = 0; i < W; i++) begin
      if (!pin_oe_n[i]) pin_in[i] = pin_out[i];
      else if (ext_en[i]) pin_in[i] = ext_val[i];
      else if (pull_en[i]) pin_in[i] = 1'b1;
      else pin_in[i] = ~pin_out[i];
    end
  end
endmodule : pin_env

// ==== port_d_e_gpio.sv ====
// port d (8 pins) and port e (2 pins) gpio with axi4-lite registers
// assumes pins are synchronous to aclk; peripherals give override hooks
`timescale 1ns/100ps
`include "gpio_consts.svh"
module port_d_e_gpio
  import gpio_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic serial_if_enable,
  input wire logic serial_tx_data,
  output logic serial_rx_data,
  input wire logic timer1_ch0_en,
  input wire logic timer1_ch1_en,
  input wire logic [1:0] timer1_drive,
  input wire logic [1:0] timer1_out,
  output logic [1:0] timer1_in,
  input wire logic timer2_ch0_en,
  input wire logic timer2_ch1_en,
  input wire logic [1:0] timer2_drive,
  input wire logic [1:0] timer2_out,
  output logic [1:0] timer2_in,
  input wire logic [4:0] converter_channel_select,
  input wire logic [7:0] pd_in,
  output logic [7:0] pd_out,
  output logic [7:0] pd_oe_n,
  output logic pullup_en_pin6,
  output logic pullup_en_pin7,
  input wire logic [1:0] pe_in,
  output logic [1:0] pe_out,
  output logic [1:0] pe_oe_n
);
  // ==========================================================
  // register state
  logic [7:0] port_d_latch_r, port_d_latch_nxt;
  logic [7:0] port_d_direction_r, port_d_direction_nxt;
  logic [7:0] port_d_pin_control_r, port_d_pin_control_nxt;
  logic [1:0] port_e_latch_r, port_e_latch_nxt;
  logic [1:0] port_e_direction_r, port_e_direction_nxt;
  logic [7:0] pd_ovr_en, pd_ovr_drive, pd_ovr_data;
  logic [1:0] pe_ovr_en;
  logic [7:0] pd_od;

  // ==========================================================
  // write channel
  wr_state_e wr_st_r, wr_st_nxt;
  logic aw_got_r, aw_got_nxt, w_got_r, w_got_nxt;
  logic [11:0] awaddr_r, awaddr_nxt;
  logic [7:0] wdata_r, wdata_nxt;
  logic wlane_r, wlane_nxt;
  logic [1:0] bresp_r, bresp_nxt;
  logic do_write;
  logic wr_hit;

  // decode shared by read and write paths
  function automatic logic addr_mapped(input logic [11:0] a);
    addr_mapped = (a == `OFF_PD_LATCH) || (a == `OFF_PE_LATCH) || (a == `OFF_PD_DIR) ||
                  (a == `OFF_PD_CTRL) || (a == `OFF_PE_DIR);
  endfunction : addr_mapped

  assign s_axi_awready = wr_st_r == WR_IDLE && !aw_got_r;
  assign s_axi_wready = wr_st_r == WR_IDLE && !w_got_r;
  assign s_axi_bvalid = wr_st_r == WR_RESP;
  assign s_axi_bresp = bresp_r;

  always_comb begin
    wr_st_nxt = wr_st_r;
    aw_got_nxt = aw_got_r;
    w_got_nxt = w_got_r;
    awaddr_nxt = awaddr_r;
    wdata_nxt = wdata_r;
    wlane_nxt = wlane_r;
    bresp_nxt = bresp_r;
    do_write = 1'b0;
    case (wr_st_r)
      WR_IDLE: begin
        if (s_axi_awvalid && s_axi_awready) begin
          aw_got_nxt = 1'b1;
          awaddr_nxt = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
          w_got_nxt = 1'b1;
          // only byte lane 0 is used; keep the low byte, written only when wstrb[0] is set
          wdata_nxt = s_axi_wdata[7:0];
          wlane_nxt = 1'b0;
          if (s_axi_wstrb[0]) begin
            wlane_nxt = 1'b1;
          end
        end
        if (aw_got_nxt && w_got_nxt) begin
          wr_st_nxt = WR_HOLD;
        end
      end
      WR_HOLD: begin
        do_write = 1'b1;
        bresp_nxt = addr_mapped(awaddr_r) ? `RESP_OKAY : `RESP_SLVERR;
        wr_st_nxt = WR_RESP;
      end
      WR_RESP: begin
        if (s_axi_bready) begin
          wr_st_nxt = WR_IDLE;
          aw_got_nxt = 1'b0;
          w_got_nxt = 1'b0;
        end
      end
      default: wr_st_nxt = WR_IDLE;
    endcase
  end

  assign wr_hit = do_write && wlane_r;

  // ==========================================================
  // register updates
  always_comb begin
    port_d_latch_nxt = port_d_latch_r;
    port_d_direction_nxt = port_d_direction_r;
    port_d_pin_control_nxt = port_d_pin_control_r;
    port_e_latch_nxt = port_e_latch_r;
    port_e_direction_nxt = port_e_direction_r;
    if (wr_hit) begin
      case (awaddr_r)
        `OFF_PD_LATCH: port_d_latch_nxt = wdata_r;
        `OFF_PE_LATCH: port_e_latch_nxt = wdata_r[1:0];
        `OFF_PD_DIR: port_d_direction_nxt = wdata_r;
        `OFF_PD_CTRL: port_d_pin_control_nxt = wdata_r & `CTRL_MASK;
        `OFF_PE_DIR: port_e_direction_nxt = wdata_r[1:0];
        default: port_d_latch_nxt = port_d_latch_r;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    // data latches keep contents through reset
    port_d_latch_r <= port_d_latch_nxt;
    port_e_latch_r <= port_e_latch_nxt;
    awaddr_r <= awaddr_nxt;
    wdata_r <= wdata_nxt;
    wlane_r <= wlane_nxt;
    if (!aresetn) begin
      port_d_direction_r <= 8'h00;
      port_e_direction_r <= 2'h0;
      port_d_pin_control_r <= 8'h00;
      wr_st_r <= WR_IDLE;
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      bresp_r <= `RESP_OKAY;
    end else begin
      port_d_direction_r <= port_d_direction_nxt;
      port_e_direction_r <= port_e_direction_nxt;
      port_d_pin_control_r <= port_d_pin_control_nxt;
      wr_st_r <= wr_st_nxt;
      aw_got_r <= aw_got_nxt;
      w_got_r <= w_got_nxt;
      bresp_r <= bresp_nxt;
    end
  end

  // ==========================================================
  // read channel
  rd_state_e rd_st_r, rd_st_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [1:0] rresp_r, rresp_nxt;
  logic [7:0] pd_rd;
  logic [1:0] pe_rd;

  always_comb begin
    // latch on outputs, pin on inputs
    pd_rd = (port_d_direction_r & port_d_latch_r) | (~port_d_direction_r & pd_in);
    pe_rd = (port_e_direction_r & port_e_latch_r) | (~port_e_direction_r & pe_in);
  end

  assign s_axi_arready = rd_st_r == RD_IDLE;
  assign s_axi_rvalid = rd_st_r == RD_RESP;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  always_comb begin
    rd_st_nxt = rd_st_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    case (rd_st_r)
      RD_IDLE: begin
        if (s_axi_arvalid) begin
          rdata_nxt = 32'h0000_0000;
          rresp_nxt = addr_mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
          case (s_axi_araddr)
            `OFF_PD_LATCH: rdata_nxt = {24'h00_0000, pd_rd};
            `OFF_PE_LATCH: rdata_nxt = {30'h000_0000, pe_rd};
            `OFF_PD_DIR: rdata_nxt = {24'h00_0000, port_d_direction_r};
            `OFF_PD_CTRL: rdata_nxt = {24'h00_0000, port_d_pin_control_r};
            `OFF_PE_DIR: rdata_nxt = {30'h000_0000, port_e_direction_r};
            default: rdata_nxt = 32'h0000_0000;
          endcase
          rd_st_nxt = RD_RESP;
        end
      end
      RD_RESP: begin
        if (s_axi_rready) begin
          rd_st_nxt = RD_IDLE;
        end
      end
      default: rd_st_nxt = RD_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_st_r <= RD_IDLE;
      rdata_r <= 32'h0000_0000;
      rresp_r <= `RESP_OKAY;
    end else begin
      rd_st_r <= rd_st_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
    end
  end

  // ==========================================================
  // pin overrides
  always_comb begin
    pd_ovr_en = 8'h00;
    pd_ovr_drive = 8'h00;
    pd_ovr_data = 8'h00;
    pd_od = 8'h00;
    // converter channel takes its pin, drive off
    if (converter_channel_select >= `ADC_CH_PD_BASE && converter_channel_select <= `ADC_CH_PD_LAST) begin
      pd_ovr_en[3'(converter_channel_select - `ADC_CH_PD_BASE) + 3'(`ADC_PIN_BASE)] = 1'b1;
    end
    // timer 1 channels on pins 4 and 5
    if (timer1_ch0_en) begin
      pd_ovr_en[4] = 1'b1;
      pd_ovr_drive[4] = timer1_drive[0];
      pd_ovr_data[4] = timer1_out[0];
    end
    if (timer1_ch1_en) begin
      pd_ovr_en[5] = 1'b1;
      pd_ovr_drive[5] = timer1_drive[1];
      pd_ovr_data[5] = timer1_out[1];
    end
    // serial owns pins 6 and 7
    if (serial_if_enable) begin
      pd_ovr_en[7:6] = 2'b11;
      pd_ovr_drive[7:6] = 2'b01;
      pd_ovr_data[7:6] = {1'b1, serial_tx_data};
    end
    pd_od[6] = port_d_pin_control_r[`CTRL_SLOW6];
    pd_od[7] = port_d_pin_control_r[`CTRL_SLOW7];
    // timer 2 channels on port e
    pe_ovr_en = {timer2_ch1_en, timer2_ch0_en};
  end

  assign pullup_en_pin6 = port_d_pin_control_r[`CTRL_PU6];
  assign pullup_en_pin7 = port_d_pin_control_r[`CTRL_PU7];
  assign serial_rx_data = pd_in[7];
  assign timer1_in = pd_in[5:4];
  assign timer2_in = pe_in;

  // ==========================================================
  // pin cells
  genvar gi;
  generate
    // direction drives each port d pin
    for (gi = 0; gi < 8; gi++) begin : g_pd
      pin_cell u_cell (
        .latch_bit(port_d_latch_r[gi]),
        .dir_bit(port_d_direction_r[gi]),
        .ovr_en(pd_ovr_en[gi]),
        .ovr_drive(pd_ovr_drive[gi]),
        .ovr_data(pd_ovr_data[gi]),
        .open_drain(pd_od[gi]),
        .pin_out(pd_out[gi]),
        .pin_oe_n(pd_oe_n[gi])
      );
    end
    for (gi = 0; gi < 2; gi++) begin : g_pe
      pin_cell u_cell (
        .latch_bit(port_e_latch_r[gi]),
        .dir_bit(port_e_direction_r[gi]),
        .ovr_en(pe_ovr_en[gi]),
        .ovr_drive(timer2_drive[gi]),
        .ovr_data(timer2_out[gi]),
        .open_drain(1'b0),
        .pin_out(pe_out[gi]),
        .pin_oe_n(pe_oe_n[gi])
      );
    end
  endgenerate
endmodule : port_d_e_gpio

// ==== port_d_e_gpio_properties.sv ====
// concurrent checks on the gpio block ports
// assumes the single aclk domain with synchronous active-low reset
`timescale 1ns/100ps
`include "gpio_consts.svh"
module port_d_e_gpio_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] pd_oe_n,
  input wire logic [7:0] pd_out,
  input wire logic [7:0] pd_in,
  input wire logic pullup_en_pin6,
  input wire logic serial_if_enable,
  input wire logic serial_tx_data,
  input wire logic serial_rx_data,
  input wire logic timer1_ch0_en,
  input wire logic [1:0] timer1_drive,
  input wire logic [1:0] timer1_out,
  input wire logic [1:0] timer1_in,
  input wire logic [4:0] converter_channel_select,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp
);
  // ==========================================
  // pin properties
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_dir_reset; $rose(aresetn) |-> pd_oe_n[3:0] == 4'hf && !pullup_en_pin6; endproperty
  a_dir_reset: assert property (p_dir_reset) else $error("port d not input after reset");
  property p_serial_rx; serial_if_enable |-> pd_oe_n[7] && serial_rx_data == pd_in[7]; endproperty
  a_serial_rx: assert property (p_serial_rx) else $error("receive pin not handed over");
  property p_serial_tx; serial_if_enable && !serial_tx_data |-> !pd_oe_n[6] && !pd_out[6]; endproperty
  a_serial_tx: assert property (p_serial_tx) else $error("transmit pin not handed over");
  property p_timer1;
    timer1_ch0_en && timer1_drive[0] |-> !pd_oe_n[4] && pd_out[4] == timer1_out[0] && timer1_in == pd_in[5:4];
  endproperty
  a_timer1: assert property (p_timer1) else $error("timer pin not handed over");
  property p_conv; converter_channel_select == 5'h08 && !timer1_ch0_en |-> pd_oe_n[4]; endproperty
  a_conv: assert property (p_conv) else $error("converter pin still driven");
  // ==========================================
  // register bus properties
  property p_wr_lat; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid;
  endproperty
  a_wr_lat: assert property (p_wr_lat) else $error("write response late or early");
  property p_wr_busy; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  a_wr_busy: assert property (p_wr_busy) else $error("write taken during response");
  property p_rd_upper; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready && s_axi_rdata[31:8] == 24'h00_0000;
  endproperty
  a_rd_upper: assert property (p_rd_upper) else $error("read answer wrong");
  property p_unmapped;
    s_axi_arvalid && s_axi_arready && !(s_axi_araddr inside {`OFF_PD_LATCH, `OFF_PE_LATCH, `OFF_PD_DIR, `OFF_PD_CTRL,
      `OFF_PE_DIR}) |=> s_axi_rresp == `RESP_SLVERR && s_axi_rdata == 32'h0000_0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
endmodule : port_d_e_gpio_checker
bind port_d_e_gpio port_d_e_gpio_checker u_chk (.*);

// ==== port_d_e_gpio_tb.sv ====
// self-checking bench for the gpio block
// assumes gpio_pkg, gpio_consts.svh, pin_env and the checker compiled before
`timescale 1ns/100ps
`include "gpio_consts.svh"
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin err_count++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, a, b); end end
module port_d_e_gpio_tb;
  // ==========================================
  // stimulus and wiring
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'h1;
  logic serial_if_enable = 1'b0, serial_tx_data = 1'b0, timer1_ch0_en = 1'b0, timer1_ch1_en = 1'b0;
  logic timer2_ch0_en = 1'b0, timer2_ch1_en = 1'b0;
  logic [1:0] timer1_drive = 2'h0, timer1_out = 2'h0, timer2_drive = 2'h0, timer2_out = 2'h0;
  logic [4:0] converter_channel_select = 5'h00;
  logic [7:0] ext_d_en = 8'h0f, ext_d_val = 8'h03;
  logic [1:0] ext_e_en = 2'h2, ext_e_val = 2'h2;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, serial_rx_data;
  logic pullup_en_pin6, pullup_en_pin7;
  logic [1:0] s_axi_bresp, s_axi_rresp, timer1_in, timer2_in, pe_in, pe_out, pe_oe_n;
  logic [31:0] s_axi_rdata;
  logic [7:0] pd_in, pd_out, pd_oe_n;
  int err_count = 0, checks_done = 0, cycles = 0;
  always #20 aclk = ~aclk;
  port_d_e_gpio dut (.*);
  pin_env #(.W(8)) env_d (.pin_out(pd_out), .pin_oe_n(pd_oe_n), .pull_en({pullup_en_pin7, pullup_en_pin6, 6'h00}),
    .ext_en(ext_d_en), .ext_val(ext_d_val), .pin_in(pd_in));
  pin_env #(.W(2)) env_e (.pin_out(pe_out), .pin_oe_n(pe_oe_n), .pull_en(2'h0), .ext_en(ext_e_en),
    .ext_val(ext_e_val), .pin_in(pe_in));
  // ==========================================
  // bus tasks: request held until its own ready edge
  task wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_hs, w_hs, b_hs;
    logic [1:0] resp;
    b_hs = 1'b0;
    resp = 2'h0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!b_hs) begin
      // sample mid-cycle: readies change at the very edge that takes the request
      @(negedge aclk);
      aw_hs = s_axi_awvalid && s_axi_awready;
      w_hs = s_axi_wvalid && s_axi_wready;
      b_hs = s_axi_bvalid;
      resp = s_axi_bresp;
      @(posedge aclk);
      if (aw_hs) s_axi_awvalid <= 1'b0;
      if (w_hs) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    `CHK(resp, er)
  endtask : wr
  task rd_chk(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
    logic ar_hs, r_hs;
    logic [33:0] got;
    r_hs = 1'b0;
    got = 34'h0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!r_hs) begin
      @(negedge aclk);
      ar_hs = s_axi_arvalid && s_axi_arready;
      r_hs = s_axi_rvalid;
      got = {s_axi_rresp, s_axi_rdata};
      @(posedge aclk);
      if (ar_hs) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    `CHK(got, {er, e})
  endtask : rd_chk
  // ==========================================
  // scenarios
  task t_reset;
    @(negedge aclk);
    `CHK({pd_oe_n, pe_oe_n}, 10'h3ff)
    rd_chk(`OFF_PD_DIR, 32'h0000_0000, `RESP_OKAY);
    rd_chk(`OFF_PE_DIR, 32'h0000_0000, `RESP_OKAY);
    rd_chk(`OFF_PD_CTRL, 32'h0000_0000, `RESP_OKAY);
  endtask : t_reset
  task t_port_d;
    wr(`OFF_PD_LATCH, 32'h0000_005a, `RESP_OKAY);
    wr(`OFF_PD_DIR, 32'h0000_00f0, `RESP_OKAY);
    `CHK({pd_oe_n, pd_out[7:4]}, 12'h0f5)
    rd_chk(`OFF_PD_LATCH, 32'h0000_0053, `RESP_OKAY);
    wr(`OFF_PD_LATCH, 32'h0000_00a5, `RESP_OKAY);
    rd_chk(`OFF_PD_LATCH, 32'h0000_00a3, `RESP_OKAY);
  endtask : t_port_d
  task t_ctrl;
    wr(`OFF_PD_CTRL, 32'hffff_ffff, `RESP_OKAY);
    rd_chk(`OFF_PD_CTRL, 32'h0000_000f, `RESP_OKAY);
    rd_chk(`OFF_PD_DIR, 32'h0000_00f0, `RESP_OKAY);
    `CHK({pd_oe_n[7:6], pd_out[6], pullup_en_pin7, pullup_en_pin6}, 5'b10011)
    wr(`OFF_PD_DIR, 32'h0000_0000, `RESP_OKAY);
    `CHK({pullup_en_pin7, pullup_en_pin6}, 2'b11)
    wr(`OFF_PD_CTRL, 32'h0000_0000, `RESP_OKAY);
    `CHK({pullup_en_pin7, pullup_en_pin6}, 2'b00)
  endtask : t_ctrl
  task t_port_e;
    wr(`OFF_PE_LATCH, 32'h0000_0001, `RESP_OKAY);
    // upper bits offered, only two kept
    wr(`OFF_PE_DIR, 32'h0000_00fd, `RESP_OKAY);
    rd_chk(`OFF_PE_DIR, 32'h0000_0001, `RESP_OKAY);
    `CHK({pe_oe_n, pe_out[0]}, 3'b101)
    rd_chk(`OFF_PE_LATCH, 32'h0000_0003, `RESP_OKAY);
    wr(`OFF_PE_LATCH, 32'h0000_0000, `RESP_OKAY);
    rd_chk(`OFF_PE_LATCH, 32'h0000_0002, `RESP_OKAY);
  endtask : t_port_e
  task t_override;
    // all port d bits made outputs
    wr(`OFF_PD_DIR, 32'h0000_00ff, `RESP_OKAY);
    @(posedge aclk);
    serial_if_enable <= 1'b1;
    timer1_ch0_en <= 1'b1;
    timer1_ch1_en <= 1'b1;
    timer1_drive <= 2'h1;
    timer1_out <= 2'h1;
    timer2_ch1_en <= 1'b1;
    timer2_drive <= 2'h2;
    timer2_out <= 2'h2;
    converter_channel_select <= 5'h08;
    @(negedge aclk);
    `CHK({pd_oe_n[7:6], pd_out[6], serial_rx_data}, {3'b100, pd_in[7]})
    `CHK({pd_oe_n[5:4], pd_out[4], timer1_in}, {3'b101, pd_in[5:4]})
    `CHK({pe_oe_n[1], pe_out[1], timer2_in}, {2'b01, pe_in})
    @(posedge aclk);
    timer1_ch0_en <= 1'b0;
    timer1_ch1_en <= 1'b0;
    timer2_ch1_en <= 1'b0;
    @(negedge aclk);
    `CHK({pd_oe_n[5:4], pe_oe_n[1]}, 3'b011)
    @(posedge aclk);
    serial_if_enable <= 1'b0;
    converter_channel_select <= 5'h00;
    @(negedge aclk);
    `CHK(pd_oe_n, 8'h00)
  endtask : t_override
  task t_unmapped_keep;
    rd_chk(12'h004, 32'h0000_0000, `RESP_SLVERR);
    wr(12'h004, 32'h0000_00ff, `RESP_SLVERR);
    @(posedge aclk);
    s_axi_wstrb <= 4'h0;
    wr(`OFF_PD_LATCH, 32'h0000_0000, `RESP_OKAY);
    s_axi_wstrb <= 4'h1;
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    `CHK({pd_oe_n, pe_oe_n}, 10'h3ff)
    wr(`OFF_PD_DIR, 32'h0000_00ff, `RESP_OKAY);
    rd_chk(`OFF_PD_LATCH, 32'h0000_00a5, `RESP_OKAY);
  endtask : t_unmapped_keep
  // ==========================================
  // run control
  task end_sim;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_sim
  // ceiling well above the hundred-odd cycles the scenarios need
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      end_sim();
    end
  end
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_port_d();
    t_ctrl();
    t_port_e();
    t_override();
    t_unmapped_keep();
    end_sim();
  end
endmodule : port_d_e_gpio_tb
